// ---- fxeu_regs.vh ----
// Constants for the fixed-point execution unit.
`ifndef FXEU_REGS_VH
`define FXEU_REGS_VH
`define FXEU_OP_NOP 4'h0
`define FXEU_OP_LOAD 4'h1
`define FXEU_OP_STORE 4'h2
`define FXEU_OP_ADD 4'h3
`define FXEU_OP_SUB 4'h4
`define FXEU_OP_CMP 4'h5
`define FXEU_OP_TRAP 4'h6
`define FXEU_OP_STRLOAD 4'h7
`define FXEU_OP_STRSTORE 4'h8
`define FXEU_OP_MOVE_MULQUO 4'h9
`define FXEU_SZ_BYTE 2'h0
`define FXEU_SZ_HALF 2'h1
`define FXEU_SZ_WORD 2'h2
`define FXEU_SRC_SIMM 2'h0
`define FXEU_SRC_UIMM 2'h1
`define FXEU_SRC_REG 2'h2
`define FXEU_IMM_HI 15
`define FXEU_IMM_LO 0
`define FXEU_A_HI 20
`define FXEU_A_LO 16
`define FXEU_B_HI 15
`define FXEU_B_LO 11
`define FXEU_RT_HI 25
`define FXEU_RT_LO 21
`define FXEU_TO_SLT 0
`define FXEU_TO_SGT 1
`define FXEU_TO_EQ 2
`define FXEU_TO_ULT 3
`define FXEU_TO_UGT 4
`define FXEU_CAUSE_NONE 2'h0
`define FXEU_CAUSE_ALIGN 2'h1
`define FXEU_CAUSE_DSI 2'h2
`define FXEU_CAUSE_TRAP 2'h3
`define FXEU_ZERO_REG 5'h00
`endif

// ---- fxeu_regfile.v ----
// General register file with three read ports and two write ports.
`timescale 1ns/10ps
module fxeu_regfile #(
	parameter WIDTH = 32,
	parameter COUNT = 32
) (
	input wire clk, // processor clock
	input wire rst, // synchronous reset
	input wire [4:0] rd_a_idx, // read port a index
	input wire [4:0] rd_b_idx, // read port b index
	input wire [4:0] rd_c_idx, // read port c index
	output wire [WIDTH-1:0] rd_a, // read port a data
	output wire [WIDTH-1:0] rd_b, // read port b data
	output wire [WIDTH-1:0] rd_c, // read port c data
	input wire wr0_en, // write port 0 enable
	input wire [4:0] wr0_idx, // write port 0 index
	input wire [WIDTH-1:0] wr0_data, // write port 0 data
	input wire wr1_en, // write port 1 enable, yields to port 0
	input wire [4:0] wr1_idx, // write port 1 index
	input wire [WIDTH-1:0] wr1_data // write port 1 data
);
	reg [WIDTH-1:0] mem [0:COUNT-1];
	genvar g;
	assign rd_a = mem[rd_a_idx];
	assign rd_b = mem[rd_b_idx];
	assign rd_c = mem[rd_c_idx];
	// Port 0 wins a same-index collision, so loaded data beats the address.
	generate
		for (g = 0; g < COUNT; g = g + 1) begin : gen_reg
			always @(posedge clk) begin
				if (rst) begin
					mem[g] <= {WIDTH{1'b0}};
				end else if (wr0_en && wr0_idx == g) begin
					mem[g] <= wr0_data;
				end else if (wr1_en && wr1_idx == g) begin
					mem[g] <= wr1_data;
				end
			end
		end
	endgenerate
endmodule

// ---- fxeu_compare.v ----
// Five-condition signed and unsigned comparator.
`timescale 1ns/10ps
`include "fxeu_regs.vh"
module fxeu_compare #(
	parameter WIDTH = 32
) (
	input wire [WIDTH-1:0] op_a, // first operand
	input wire [WIDTH-1:0] op_b, // second operand
	output wire [4:0] cond // condition bits, trap mask order
);
	assign cond[`FXEU_TO_SLT] = $signed(op_a) < $signed(op_b);
	assign cond[`FXEU_TO_SGT] = $signed(op_a) > $signed(op_b);
	assign cond[`FXEU_TO_EQ] = op_a == op_b;
	assign cond[`FXEU_TO_ULT] = op_a < op_b;
	assign cond[`FXEU_TO_UGT] = op_a > op_b;
endmodule

// ---- fxeu_unit.v ----
// Fixed-point execution unit: registers, loads, stores, compares, traps.
`timescale 1ns/10ps
`include "fxeu_regs.vh"
// Operation
// - Thirty-two 32-bit general registers plus one 32-bit exception register.
// - Older variant also holds a 32-bit multiply-quotient register.
// - Load computes address and writes byte, half or word unless faulted.
// - Store writes source register to memory unless faulted.
// - Unaligned access completes in hardware or raises alignment interrupt.
// - Update form writes effective address back into base register.
// - Older variant: base equal destination ends holding loaded data.
// - Older variant: no write-back for base zero or faulted access.
// - Newer variant: update with base zero, or load update with base equal destination, invalid.
// - Zero-length indexed string move leaves destination unchanged.
// - Arithmetic treats operands as 32-bit two's-complement signed.
// - Compare against signed immediate, unsigned immediate or second register.
// - Algebraic compares are signed, logical compares unsigned.
// - Trap compares against signed immediate or second register by opcode.
// - Trap uses only the low 32 bits of both operands.
// - Five condition bits ANDed with mask; nonzero result traps.
// - Unsigned immediate taken from bits 16 to 31 as 16-bit unsigned.
// - Signed immediate taken from bits 16 to 31 as 16-bit signed.
// - First operand index from bits 11-15, second from bits 16-20.
// - Mask bit 0 signed less, bit 1 signed greater, bit 2 equal.
module fxeu_unit #(
	parameter WIDTH = 32,
	parameter OLD_VARIANT = 1,
	parameter HW_UNALIGNED = 0
) (
	input wire clk, // processor clock
	input wire rst, // synchronous reset
	input wire issue_valid, // instruction presented this cycle
	output wire issue_ready, // unit can take an instruction
	input wire [31:0] issue_instr, // instruction word, bit 31 is msb-0 bit 0
	input wire [3:0] issue_op, // decoded operation
	input wire [1:0] issue_size, // access size
	input wire [1:0] issue_src, // second operand source
	input wire issue_logical, // compare is unsigned
	input wire issue_update, // update form of load or store
	input wire issue_signext, // sign-extend loaded data
	input wire [6:0] issue_strlen, // string length in bytes, at most 4 here
	input wire mulquo_wr, // write multiply-quotient from operand a
	output reg mem_req, // data storage request
	output reg mem_we, // request is a write
	output reg [31:0] mem_addr, // effective address
	output reg [3:0] mem_be, // byte enables, lane 0 is bits 7:0
	output reg [31:0] mem_wdata, // write data in lanes
	input wire mem_ack, // storage answer
	input wire mem_fault, // storage answer is a data storage fault
	input wire [31:0] mem_rdata, // read data in lanes
	output reg exc_valid, // interrupt raised, one cycle
	output reg [1:0] exc_cause, // interrupt cause
	output reg [31:0] exc_addr, // faulting effective address
	output reg invalid_form, // invalid instruction form, one cycle
	output reg [4:0] cmp_result, // last compare condition bits
	output reg cmp_valid, // compare result new, one cycle
	output reg done, // instruction retired, one cycle
	output reg [31:0] xer, // exception register, carry in bit 29
	output reg [31:0] multiply_quotient_reg, // older-variant register
	output reg [31:0] alu_result // last arithmetic result
);
	localparam ST_IDLE = 2'h0;
	localparam ST_MEM = 2'h1;
	localparam ST_STR = 2'h2;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [4:0] rt_q;
	reg [4:0] base_q;
	reg [1:0] size_q;
	reg upd_q;
	reg sext_q;
	reg we_q;
	reg [1:0] off_q;
	wire [4:0] operand_a_reg = issue_instr[`FXEU_A_HI:`FXEU_A_LO];
	wire [4:0] operand_b_reg = issue_instr[`FXEU_B_HI:`FXEU_B_LO];
	wire [4:0] dest_reg = issue_instr[`FXEU_RT_HI:`FXEU_RT_LO];
	wire [15:0] imm = issue_instr[`FXEU_IMM_HI:`FXEU_IMM_LO];
	wire [31:0] signed_immediate = {{16{imm[15]}}, imm};
	wire [31:0] unsigned_immediate = {16'h0000, imm};
	wire [4:0] trap_condition_mask = dest_reg;
	wire [WIDTH-1:0] a_val;
	wire [WIDTH-1:0] b_val;
	wire [WIDTH-1:0] rt_val;
	reg wr0_en;
	reg [4:0] wr0_idx;
	reg [WIDTH-1:0] wr0_data;
	reg wr1_en;
	reg [4:0] wr1_idx;
	reg [WIDTH-1:0] wr1_data;
	fxeu_regfile #(.WIDTH(WIDTH), .COUNT(32)) u_regs (
		.clk(clk),
		.rst(rst),
		.rd_a_idx(operand_a_reg),
		.rd_b_idx(operand_b_reg),
		.rd_c_idx(dest_reg),
		.rd_a(a_val),
		.rd_b(b_val),
		.rd_c(rt_val),
		.wr0_en(wr0_en),
		.wr0_idx(wr0_idx),
		.wr0_data(wr0_data),
		.wr1_en(wr1_en),
		.wr1_idx(wr1_idx),
		.wr1_data(wr1_data)
	);
	// Base register zero reads as zero for address formation.
	wire [31:0] base = (operand_a_reg == `FXEU_ZERO_REG) ? 32'h00000000 :
		a_val[31:0];
	wire [31:0] effective_addr = base + signed_immediate;
	function is_misaligned;
		input [1:0] sz;
		input [1:0] lo;
		begin
			case (sz)
				`FXEU_SZ_HALF: is_misaligned = lo[0];
				`FXEU_SZ_WORD: is_misaligned = lo != 2'h0;
				default: is_misaligned = 1'b0;
			endcase
		end
	endfunction
	function [3:0] lane_mask;
		input [1:0] sz;
		input [1:0] lo;
		begin
			case (sz)
				`FXEU_SZ_BYTE: lane_mask = 4'h1 << lo;
				`FXEU_SZ_HALF: lane_mask = 4'h3 << lo;
				default: lane_mask = 4'hF;
			endcase
		end
	endfunction
	wire mem_op = issue_op == `FXEU_OP_LOAD || issue_op == `FXEU_OP_STORE;
	wire misalign = mem_op && is_misaligned(issue_size, effective_addr[1:0]);
	wire align_trap = misalign && (HW_UNALIGNED == 0);
	wire bad_form = mem_op && issue_update && (OLD_VARIANT == 0) &&
		(operand_a_reg == `FXEU_ZERO_REG ||
		(issue_op == `FXEU_OP_LOAD && operand_a_reg == dest_reg));
	wire [31:0] cmp_b = (issue_src == `FXEU_SRC_SIMM) ? signed_immediate :
		(issue_src == `FXEU_SRC_UIMM) ? unsigned_immediate : b_val[31:0];
	// The trap form only chooses the signed immediate or the second register.
	wire [31:0] trap_b = (issue_src == `FXEU_SRC_SIMM) ? signed_immediate :
		b_val[31:0];
	wire [4:0] cmp_cond;
	wire [4:0] trap_cond;
	fxeu_compare #(.WIDTH(32)) u_cmp (
		.op_a(a_val[31:0]),
		.op_b(cmp_b),
		.cond(cmp_cond)
	);
	fxeu_compare #(.WIDTH(32)) u_trap (
		.op_a(a_val[31:0]),
		.op_b(trap_b),
		.cond(trap_cond)
	);
	wire trap_hit = |(trap_cond & trap_condition_mask);
	wire [32:0] add_full = {1'b0, a_val[31:0]} + {1'b0, cmp_b};
	wire [32:0] sub_full = {1'b0, a_val[31:0]} - {1'b0, cmp_b};
	// Signed overflow: add when operand signs agree, sub when they differ, and the result sign differs from a.
	wire add_ov = a_val[31] == cmp_b[31] && add_full[31] != a_val[31];
	wire sub_ov = a_val[31] != cmp_b[31] && sub_full[31] != a_val[31];
	wire [2:0] rd_lane = {1'b0, off_q};
	wire [31:0] shifted = mem_rdata >> {rd_lane, 3'h0};
	reg [31:0] load_val;
	always @* begin
		case (size_q)
			`FXEU_SZ_BYTE: load_val = {{24{sext_q & shifted[7]}},
				shifted[7:0]};
			`FXEU_SZ_HALF: load_val = {{16{sext_q & shifted[15]}},
				shifted[15:0]};
			default: load_val = shifted;
		endcase
	end
	assign issue_ready = state == ST_IDLE;
	wire take = issue_valid && issue_ready;
	wire str_op = issue_op == `FXEU_OP_STRLOAD ||
		issue_op == `FXEU_OP_STRSTORE;
	wire str_empty = issue_strlen == 7'h00;
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take && mem_op && !align_trap && !bad_form) begin
					next_state = ST_MEM;
				end else if (take && str_op && !str_empty) begin
					next_state = ST_STR;
				end
			end
			ST_MEM: begin
				if (mem_ack) begin
					next_state = ST_IDLE;
				end
			end
			ST_STR: begin
				if (mem_ack) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end
	// Port 0 carries results and loaded data; port 1 carries the address.
	always @* begin
		wr0_en = 1'b0;
		wr0_idx = rt_q;
		wr0_data = {{(WIDTH-32){1'b0}}, load_val};
		wr1_en = 1'b0;
		wr1_idx = base_q;
		wr1_data = {{(WIDTH-32){1'b0}}, mem_addr};
		case (state)
			ST_IDLE: begin
				if (take && issue_op == `FXEU_OP_ADD) begin
					wr0_en = 1'b1;
					wr0_idx = dest_reg;
					wr0_data = {{(WIDTH-32){1'b0}}, add_full[31:0]};
				end else if (take && issue_op == `FXEU_OP_SUB) begin
					wr0_en = 1'b1;
					wr0_idx = dest_reg;
					wr0_data = {{(WIDTH-32){1'b0}}, sub_full[31:0]};
				end
			end
			ST_MEM, ST_STR: begin
				// A faulted access writes nothing at all.
				wr0_en = mem_ack && !mem_fault && !we_q;
				wr1_en = mem_ack && !mem_fault && upd_q &&
					base_q != `FXEU_ZERO_REG;
				// Same index: port 0 has priority in the file.
				if (base_q == rt_q && !we_q) begin
					wr1_en = wr1_en && (OLD_VARIANT == 0);
				end
			end
			default: begin
				wr0_en = 1'b0;
			end
		endcase
	end
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			rt_q <= 5'h00;
			base_q <= 5'h00;
			size_q <= `FXEU_SZ_WORD;
			upd_q <= 1'b0;
			sext_q <= 1'b0;
			we_q <= 1'b0;
			off_q <= 2'h0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_be <= 4'h0;
			mem_wdata <= 32'h00000000;
			exc_valid <= 1'b0;
			exc_cause <= `FXEU_CAUSE_NONE;
			exc_addr <= 32'h00000000;
			invalid_form <= 1'b0;
			cmp_result <= 5'h00;
			cmp_valid <= 1'b0;
			done <= 1'b0;
			xer <= 32'h00000000;
			multiply_quotient_reg <= 32'h00000000;
			alu_result <= 32'h00000000;
		end else begin
			state <= next_state;
			exc_valid <= 1'b0;
			invalid_form <= 1'b0;
			cmp_valid <= 1'b0;
			done <= 1'b0;
			if (mulquo_wr && OLD_VARIANT != 0) begin
				multiply_quotient_reg <= a_val[31:0];
			end
			if (take) begin
				rt_q <= dest_reg;
				base_q <= operand_a_reg;
				size_q <= str_op ? `FXEU_SZ_WORD : issue_size;
				upd_q <= issue_update && mem_op;
				sext_q <= issue_signext;
				we_q <= issue_op == `FXEU_OP_STORE ||
					issue_op == `FXEU_OP_STRSTORE;
				off_q <= effective_addr[1:0];
				mem_addr <= effective_addr;
				mem_we <= issue_op == `FXEU_OP_STORE ||
					issue_op == `FXEU_OP_STRSTORE;
				mem_be <= lane_mask(str_op ? `FXEU_SZ_WORD : issue_size,
					effective_addr[1:0]);
				mem_wdata <= rt_val[31:0] << {effective_addr[1:0], 3'h0};
				case (issue_op)
					`FXEU_OP_LOAD, `FXEU_OP_STORE: begin
						if (bad_form) begin
							invalid_form <= 1'b1;
							done <= 1'b1;
						end else if (align_trap) begin
							exc_valid <= 1'b1;
							exc_cause <= `FXEU_CAUSE_ALIGN;
							exc_addr <= effective_addr;
							done <= 1'b1;
						end else begin
							mem_req <= 1'b1;
						end
					end
					`FXEU_OP_STRLOAD, `FXEU_OP_STRSTORE: begin
						// Zero length retires with no access.
						if (str_empty) begin
							done <= 1'b1;
						end else begin
							mem_req <= 1'b1;
						end
					end
					`FXEU_OP_ADD: begin
						alu_result <= add_full[31:0];
						xer[29] <= add_full[32];
						xer[30] <= add_ov;
						xer[31] <= xer[31] | add_ov;
						done <= 1'b1;
					end
					`FXEU_OP_SUB: begin
						alu_result <= sub_full[31:0];
						xer[29] <= ~sub_full[32];
						xer[30] <= sub_ov;
						xer[31] <= xer[31] | sub_ov;
						done <= 1'b1;
					end
					`FXEU_OP_CMP: begin
						cmp_valid <= 1'b1;
						cmp_result <= issue_logical ?
							{cmp_cond[`FXEU_TO_UGT], cmp_cond[`FXEU_TO_ULT],
							cmp_cond[`FXEU_TO_EQ], cmp_cond[`FXEU_TO_UGT],
							cmp_cond[`FXEU_TO_ULT]} : cmp_cond;
						done <= 1'b1;
					end
					`FXEU_OP_TRAP: begin
						cmp_result <= trap_cond;
						if (trap_hit) begin
							exc_valid <= 1'b1;
							exc_cause <= `FXEU_CAUSE_TRAP;
							exc_addr <= 32'h00000000;
						end
						done <= 1'b1;
					end
					default: begin
						done <= 1'b1;
					end
				endcase
			end else if (state != ST_IDLE && mem_ack) begin
				mem_req <= 1'b0;
				done <= 1'b1;
				if (mem_fault) begin
					exc_valid <= 1'b1;
					exc_cause <= `FXEU_CAUSE_DSI;
					exc_addr <= mem_addr;
				end
			end
		end
	end
endmodule

// ---- fxeu_unit_properties.sv ----
// Port assertions for the fixed-point execution unit.
`timescale 1ns/10ps
`include "fxeu_regs.vh"
module fxeu_unit_chk #(
	parameter HW_UNALIGNED = 0
) (
	input wire clk, // clock
	input wire rst, // reset
	input wire issue_valid, // offer
	input wire issue_ready, // idle
	input wire [31:0] issue_instr, // word
	input wire [3:0] issue_op, // operation
	input wire [1:0] issue_src, // source
	input wire mem_req, // request
	input wire [31:0] mem_addr, // address
	input wire [3:0] mem_be, // enables
	input wire mem_ack, // answer
	input wire mem_fault, // fault
	input wire exc_valid, // interrupt
	input wire [1:0] exc_cause, // cause
	input wire [31:0] exc_addr, // fault address
	input wire invalid_form, // bad form
	input wire cmp_valid, // compare
	input wire done // retire
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	wire take = issue_valid && issue_ready;
	wire mem_op = issue_op == `FXEU_OP_LOAD || issue_op == `FXEU_OP_STORE;
	wire trap_op = take && issue_op == `FXEU_OP_TRAP;
	property p_req_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_be);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request moved before answer");
	property p_ack_done;
		mem_req && mem_ack |=> !mem_req && done;
	endproperty
	a_ack_done: assert property (p_ack_done)
		else $error("no retire after answer");
	property p_dsi;
		mem_req && mem_ack && mem_fault |=> exc_valid &&
			exc_cause == `FXEU_CAUSE_DSI && exc_addr == $past(mem_addr);
	endproperty
	a_dsi: assert property (p_dsi)
		else $error("storage fault not raised");
	property p_lane;
		mem_req |-> mem_be[mem_addr[1:0]] &&
			(HW_UNALIGNED != 0 || mem_be != 4'hF || mem_addr[1:0] == 2'h0);
	endproperty
	a_lane: assert property (p_lane)
		else $error("bad lane or unaligned word");
	property p_busy;
		mem_req |-> !issue_ready;
	endproperty
	a_busy: assert property (p_busy)
		else $error("ready during access");
	property p_mem_take;
		take && mem_op |=> mem_req || invalid_form ||
			(exc_valid && exc_cause == `FXEU_CAUSE_ALIGN);
	endproperty
	a_mem_take: assert property (p_mem_take)
		else $error("access neither started nor refused");
	property p_cmp;
		take && issue_op == `FXEU_OP_CMP |=> cmp_valid && done;
	endproperty
	a_cmp: assert property (p_cmp)
		else $error("compare gave no result");
	property p_trap_off;
		trap_op && issue_instr[25:21] == 5'h00 |=> done && !exc_valid;
	endproperty
	a_trap_off: assert property (p_trap_off)
		else $error("trap with empty mask");
	property p_trap_eq;
		trap_op && issue_src == `FXEU_SRC_REG && issue_instr[23] &&
			issue_instr[20:16] == issue_instr[15:11] |=>
			exc_valid && exc_cause == `FXEU_CAUSE_TRAP;
	endproperty
	a_trap_eq: assert property (p_trap_eq)
		else $error("equal trap missed");
	c_dsi: cover property (mem_req && mem_ack && mem_fault);
	c_align: cover property (exc_valid && exc_cause == `FXEU_CAUSE_ALIGN);
	c_trap: cover property (exc_valid && exc_cause == `FXEU_CAUSE_TRAP);
endmodule
bind fxeu_unit fxeu_unit_chk #(.HW_UNALIGNED(HW_UNALIGNED)) fxeu_unit_chk_i (
	.clk, .rst, .issue_valid, .issue_ready, .issue_instr, .issue_op,
	.issue_src, .mem_req, .mem_addr, .mem_be, .mem_ack, .mem_fault,
	.exc_valid, .exc_cause, .exc_addr, .invalid_form, .cmp_valid, .done
);

// ---- fxeu_mem_model.sv ----
// Data storage responder facing the fixed-point execution unit.
`timescale 1ns/10ps
module fxeu_mem_model (
	input wire clk, // clock
	input wire rst, // reset
	input wire slow, // answer after three waits
	input wire mem_req, // request
	input wire mem_we, // write
	input wire [31:0] mem_addr, // address
	input wire [3:0] mem_be, // enables
	input wire [31:0] mem_wdata, // write data
	output logic mem_ack, // answer pulse
	output logic mem_fault, // fault, set for address bit 14
	output logic [31:0] mem_rdata // read data
);
	logic [31:0] mem [16];
	logic [1:0] wait_cnt;
	// Outside an answer the data lines toggle so stale values never match.
	always @(posedge clk) begin
		mem_ack <= 1'h0;
		mem_fault <= ~mem_fault;
		mem_rdata <= ~mem_rdata;
		if (rst) begin
			wait_cnt <= 2'h0;
			mem_fault <= 1'h0;
			mem_rdata <= 32'h0;
			foreach (mem[i])
				mem[i] <= 32'h0;
		end else if (mem_req && !mem_ack) begin
			if (slow && wait_cnt != 2'h3) begin
				wait_cnt <= wait_cnt + 2'h1;
			end else begin
				wait_cnt <= 2'h0;
				mem_ack <= 1'h1;
				mem_fault <= mem_addr[14];
				mem_rdata <= mem[mem_addr[5:2]];
				for (int b = 0; b < 4; b++)
					if (mem_we && !mem_addr[14] && mem_be[b])
						mem[mem_addr[5:2]][8*b+:8] <= mem_wdata[8*b+:8];
			end
		end
	end
endmodule

// ---- fxeu_unit_tb.sv ----
// Self-checking bench for the fixed-point execution unit.
`timescale 1ns/10ps
`include "fxeu_regs.vh"
module fxeu_unit_tb;
	typedef struct packed {
		logic [3:0] op;
		logic [1:0] src;
		logic lg;
		logic [31:0] word;
		logic [2:0] exp;
	} fxeu_row_t;
	localparam logic [3:0] CM = `FXEU_OP_CMP;
	localparam logic [3:0] TR = `FXEU_OP_TRAP;
	localparam logic [3:0] LD = `FXEU_OP_LOAD;
	localparam logic [3:0] ST = `FXEU_OP_STORE;
	localparam logic [1:0] W = `FXEU_SZ_WORD;
	localparam logic [1:0] B = `FXEU_SZ_BYTE;
	logic clk, rst, issue_valid, issue_logical, issue_update, slow, mulquo_wr;
	logic [3:0] issue_op;
	logic [1:0] issue_size, issue_src;
	logic [6:0] issue_strlen;
	logic [31:0] issue_instr;
	wire issue_ready, mem_req, mem_we, mem_ack, mem_fault, exc_valid;
	wire invalid_form, cmp_valid, done;
	wire [31:0] mem_addr, mem_wdata, mem_rdata, exc_addr, xer, alu_result;
	wire [31:0] multiply_quotient_reg;
	wire [3:0] mem_be;
	wire [1:0] exc_cause;
	wire [4:0] cmp_result;
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Register 1 holds -2 and register 2 holds 5; mask sits in bits 25:21.
	fxeu_row_t rows [12] = '{
		'{CM, 2'h2, 1'h0, 32'h0001_1000, 3'h1},
		'{CM, 2'h2, 1'h1, 32'h0001_1000, 3'h2},
		'{CM, 2'h0, 1'h0, 32'h0002_0005, 3'h4},
		'{CM, 2'h0, 1'h0, 32'h0001_FFFE, 3'h4},
		'{CM, 2'h1, 1'h1, 32'h0001_FFFE, 3'h2},
		'{TR, 2'h2, 1'h0, 32'h0101_1000, 3'h0},
		'{TR, 2'h2, 1'h0, 32'h0201_1000, 3'h1},
		'{TR, 2'h2, 1'h0, 32'h0021_1000, 3'h1},
		'{TR, 2'h0, 1'h0, 32'h0042_FFFE, 3'h1},
		'{TR, 2'h0, 1'h0, 32'h0082_0005, 3'h1},
		'{TR, 2'h2, 1'h0, 32'h0082_1000, 3'h1},
		'{TR, 2'h0, 1'h0, 32'h0002_0005, 3'h0}
	};
	fxeu_unit #(.OLD_VARIANT(1), .HW_UNALIGNED(0)) fxeu_unit_i (
		.clk, .rst, .issue_valid, .issue_ready, .issue_instr, .issue_op,
		.issue_size, .issue_src, .issue_logical, .issue_update,
		.issue_signext(1'h0), .issue_strlen, .mulquo_wr, .mem_req,
		.mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_fault,
		.mem_rdata, .exc_valid, .exc_cause, .exc_addr, .invalid_form,
		.cmp_result, .cmp_valid, .done, .xer, .multiply_quotient_reg,
		.alu_result
	);
	fxeu_mem_model fxeu_mem_model_i (
		.clk, .rst, .slow, .mem_req, .mem_we, .mem_addr, .mem_be,
		.mem_wdata, .mem_ack, .mem_fault, .mem_rdata
	);
	function automatic logic [31:0] ins(input logic [4:0] t, a,
			input logic [15:0] imm);
		return {6'h00, t, a, imm};
	endfunction
	task automatic check(input logic [31:0] got, exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic run(input logic [3:0] op, input logic [31:0] word,
			input logic [1:0] src, sz, input logic lg, up);
		int n;
		@(negedge clk);
		issue_op = op;
		issue_instr = word;
		issue_src = src;
		issue_size = sz;
		issue_logical = lg;
		issue_update = up;
		issue_valid = 1'h1;
		@(negedge clk);
		issue_valid = 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n == 20)
			check(32'h0, 32'h1, "no retire");
	endtask
	task automatic add(input logic [4:0] t, a, input logic [15:0] imm,
			input logic [31:0] exp);
		run(`FXEU_OP_ADD, ins(t, a, imm), `FXEU_SRC_SIMM, W, 1'h0, 1'h0);
		check(alu_result, exp, "add");
	endtask
	task automatic mem(input logic [3:0] op, input logic [4:0] t, a,
			input logic [15:0] imm, input logic [1:0] sz, input logic up);
		run(op, ins(t, a, imm), `FXEU_SRC_SIMM, sz, 1'h0, up);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		rst = 1'h1;
		slow = 1'h0;
		mulquo_wr = 1'h0;
		issue_valid = 1'h0;
		issue_op = 4'h0;
		issue_instr = 32'h0;
		issue_size = 2'h0;
		issue_src = 2'h0;
		issue_logical = 1'h0;
		issue_update = 1'h0;
		issue_strlen = 7'h00;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		check(32'({issue_ready, done, mem_req}), 32'h4, "idle");
		check(xer, 32'h0, "xer");
		check(multiply_quotient_reg, 32'h0, "multiply quotient");
		add(5'h01, 5'h03, 16'hFFFE, 32'hFFFF_FFFE);
		add(5'h02, 5'h03, 16'h0005, 32'h0000_0005);
		add(5'h07, 5'h03, 16'h0004, 32'h0000_0004);
		run(`FXEU_OP_SUB, ins(5'h1F, 5'h02, 16'h0007), `FXEU_SRC_SIMM, W,
			1'h0, 1'h0);
		check(alu_result, 32'hFFFF_FFFE, "sub");
		issue_instr = ins(5'h00, 5'h02, 16'h0000);
		mulquo_wr = 1'h1;
		@(negedge clk);
		mulquo_wr = 1'h0;
		check(multiply_quotient_reg, 32'h0000_0005, "quotient write");
		$display("Test reset and setup finished");
		foreach (rows[i]) begin
			run(rows[i].op, rows[i].word, rows[i].src, W, rows[i].lg, 1'h0);
			if (rows[i].op == CM)
				check(32'(cmp_result[2:0]), 32'(rows[i].exp), "cmp");
			else
				check(32'(exc_valid), 32'(rows[i].exp[0]), "trap");
			if (rows[i].op == TR && rows[i].exp[0])
				check(32'(exc_cause), 32'h3, "cause");
		end
		$display("Test compare and trap table finished");
		slow = 1'h1;
		mem(ST, 5'h02, 5'h03, 16'h0008, W, 1'h0);
		mem(ST, 5'h01, 5'h03, 16'h0009, B, 1'h0);
		slow = 1'h0;
		mem(LD, 5'h04, 5'h03, 16'h0008, W, 1'h0);
		add(5'h1F, 5'h04, 16'h0000, 32'h0000_FE05);
		mem(LD, 5'h0A, 5'h03, 16'h0009, B, 1'h0);
		add(5'h1F, 5'h0A, 16'h0000, 32'h0000_00FE);
		mem(LD, 5'h06, 5'h07, 16'h0004, W, 1'h1);
		add(5'h1F, 5'h06, 16'h0000, 32'h0000_FE05);
		add(5'h1F, 5'h07, 16'h0000, 32'h0000_0008);
		mem(LD, 5'h07, 5'h07, 16'h0000, W, 1'h1);
		add(5'h1F, 5'h07, 16'h0000, 32'h0000_FE05);
		$display("Test load and store finished");
		mem(LD, 5'h09, 5'h08, 16'h0002, W, 1'h1);
		check(32'({exc_valid, exc_cause}), 32'h5, "align");
		check(exc_addr, 32'h0000_0002, "align addr");
		mem(LD, 5'h09, 5'h08, 16'h4000, W, 1'h1);
		check(32'({exc_valid, exc_cause}), 32'h6, "dsi");
		check(exc_addr, 32'h0000_4000, "dsi addr");
		add(5'h1F, 5'h09, 16'h0000, 32'h0);
		add(5'h1F, 5'h08, 16'h0000, 32'h0);
		mem(ST, 5'h02, 5'h00, 16'h000C, W, 1'h1);
		add(5'h1F, 5'h00, 16'h0000, 32'h0);
		mem(`FXEU_OP_STRLOAD, 5'h01, 5'h03, 16'h0008, W, 1'h0);
		add(5'h1F, 5'h01, 16'h0000, 32'hFFFF_FFFE);
		$display("Test faults and strings finished");
		wrap_up();
	end
endmodule
